//--- rtl/gpc_pkg.sv
// constants for the general-purpose port block with change detection
// assumes one 50 MHz clock and a plain strobe-based register port
//
// Overview of operation
// - second port has eight pins, each usable as input or output
// - direction bit 1 puts that pin's driver into high impedance
// - direction bit 0 drives the pin from its output latch bit
// - latch register reads back stored latch value, writes update latch
// - clearing global pull-up bit 7 of control two enables all pull-ups
// - pull-up of any second-port pin set as output is switched off
// - pull-ups are off after power-on reset
// - after reset low four pins analog reading 0, upper four digital inputs
// - change detection covers upper four pins only, outputs excluded
// - eligible pins compared against snapshot taken at last port read or write
// - mismatches ORed to set change flag, bit 0 of main control
// - change flag can wake the device from sleep and idle
// - flag keeps setting during mismatch; port read ends it, clear later
// - first-port pin five digital input off while analog, latch unaffected
// - first-port pin five defaults to analog channel four after reset
// - in RC/EC modes first-port pin six outputs quarter-rate cycle clock
// - bit 4 of first-port pin, latch, direction registers reads 0
// - overriding alternate functions ignore the direction bit
package gpc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_PA_PINS = 4'h0;
    localparam logic [3:0] REG_PA_LATCH = 4'h1;
    localparam logic [3:0] REG_PA_DIR = 4'h2;
    localparam logic [3:0] REG_ANA_LOW = 4'h3;
    localparam logic [3:0] REG_PB_PINS = 4'h4;
    localparam logic [3:0] REG_PB_LATCH = 4'h5;
    localparam logic [3:0] REG_PB_DIR = 4'h6;
    localparam logic [3:0] REG_ANA_HIGH = 4'h7;
    localparam logic [3:0] REG_INT_TWO = 4'h8;
    localparam logic [3:0] REG_INT_MAIN = 4'h9;
    // ---------------------------------------------------------------
    // reset values and field layout
    // ---------------------------------------------------------------
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PA_DIR_RST = 8'hEF;
    localparam logic [7:0] PB_DIR_RST = 8'hFF;
    localparam logic [7:0] ANA_RST = 8'h00;
    localparam logic [7:0] INT_TWO_RST = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] PA_IMPL_MASK = 8'hEF;
    localparam logic [7:0] PB_IOC_MASK = 8'hF0;
    localparam logic [7:0] PB_ANA_MASK = 8'h0F;
    localparam int PA_UNIMPL_BIT = 4;
    localparam int PA_ANALOG_PIN = 5;
    localparam int PA_CLKOUT_PIN = 6;
    localparam int ANA_CH4_BIT = 4;
    localparam int PULLUP_BIT = 7;
    localparam int FLAG_BIT = 0;
    localparam int IOC_LSB = 4;
    localparam int CYCLE_DIV = 4;
endpackage

//--- rtl/gpc_port.sv
// two general-purpose pin ports with pull-ups and change detection
// assumes a one-cycle strobe register master on the same clock
//
// Chosen here: the address map and the strobed register port.
module gpc_port
    import gpc_pkg::*;
#(
    parameter int PB_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [7:0] pa_pin_in,
    output logic [7:0] pa_pin_out,
    output logic [7:0] pa_pin_oe_n,
    input wire logic [PB_WIDTH-1:0] pb_pin_in,
    output logic [PB_WIDTH-1:0] pb_pin_out,
    output logic [PB_WIDTH-1:0] pb_pin_oe_n,
    output logic [PB_WIDTH-1:0] pb_pullup_en,
    input wire logic rc_ec_mode,
    output logic wake_request
);
    localparam int DIV_W = $clog2(CYCLE_DIV);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [7:0] pa_sync;
    logic [PB_WIDTH-1:0] pb_sync;

    gpc_sync #(.WIDTH(8)) u_sync_a (
        .clock(clock),
        .rstn(rstn),
        .async_in(pa_pin_in),
        .sync_out(pa_sync)
    );

    gpc_sync #(.WIDTH(PB_WIDTH)) u_sync_b (
        .clock(clock),
        .rstn(rstn),
        .async_in(pb_pin_in),
        .sync_out(pb_sync)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] pa_latch;
    logic [7:0] pa_dir;
    logic [7:0] ana_low;
    logic [PB_WIDTH-1:0] pb_latch;
    logic [PB_WIDTH-1:0] pb_dir;
    logic [7:0] ana_high;
    logic [7:0] int_two;
    logic port_change_flag;
    logic [3:0] ioc_snap;
    logic ioc_mismatch;
    logic [DIV_W-1:0] div_cnt;
    logic [7:0] next_pa_latch;
    logic [7:0] next_pa_dir;
    logic [7:0] next_ana_low;
    logic [PB_WIDTH-1:0] next_pb_latch;
    logic [PB_WIDTH-1:0] next_pb_dir;
    logic [7:0] next_ana_high;
    logic [7:0] next_int_two;
    logic next_port_change_flag;
    logic [3:0] next_ioc_snap;
    logic next_ioc_mismatch;
    logic [DIV_W-1:0] next_div_cnt;
    logic [DATA_W-1:0] next_rdata;
    logic [7:0] next_pa_pin_out;
    logic [7:0] next_pa_pin_oe_n;
    logic [PB_WIDTH-1:0] next_pb_pin_out;
    logic [PB_WIDTH-1:0] next_pb_pin_oe_n;
    logic [PB_WIDTH-1:0] next_pb_pullup_en;
    logic next_wake_request;
    logic [7:0] pa_dig;
    logic [PB_WIDTH-1:0] pb_dig;
    logic pb_access;

    // ---------------------------------------------------------------
    // digital input paths
    // ---------------------------------------------------------------
    // analog pins read as zero so a floating analog level never toggles
    always_comb begin
        pa_dig = pa_sync & PA_IMPL_MASK;
        if (!ana_low[ANA_CH4_BIT]) begin
            pa_dig[PA_ANALOG_PIN] = 1'b0;
        end
        pb_dig = pb_sync & ~(PB_ANA_MASK & ~ana_high);
    end

    // any read or write of the second port's pin register refreshes the snapshot
    assign pb_access = (rd || wr) && (addr == REG_PB_PINS);

    // ---------------------------------------------------------------
    // register and pin next values
    // ---------------------------------------------------------------
    always_comb begin
        next_pa_latch = pa_latch;
        next_pa_dir = pa_dir;
        next_ana_low = ana_low;
        next_pb_latch = pb_latch;
        next_pb_dir = pb_dir;
        next_ana_high = ana_high;
        next_int_two = int_two;
        next_port_change_flag = port_change_flag;
        next_ioc_snap = ioc_snap;
        next_div_cnt = div_cnt + DIV_W'(1);
        next_rdata = ZERO_BYTE;
        // register writes
        if (wr) begin
            case (addr)
                REG_PA_PINS, REG_PA_LATCH: next_pa_latch = wdata & PA_IMPL_MASK;
                REG_PA_DIR: next_pa_dir = wdata & PA_IMPL_MASK;
                REG_ANA_LOW: next_ana_low = wdata;
                REG_PB_PINS, REG_PB_LATCH: next_pb_latch = wdata;
                REG_PB_DIR: next_pb_dir = wdata;
                REG_ANA_HIGH: next_ana_high = wdata & PB_ANA_MASK;
                REG_INT_TWO: next_int_two = wdata;
                REG_INT_MAIN: next_port_change_flag = wdata[FLAG_BIT];
                default: begin
                end
            endcase
        end
        // a pending mismatch beats a software clear in the same cycle
        if (ioc_mismatch) begin
            next_port_change_flag = 1'b1;
        end
        if (pb_access) begin
            next_ioc_snap = pb_dig[7:IOC_LSB];
        end
        // read data, zero outside the cycle after a read
        if (rd) begin
            case (addr)
                REG_PA_PINS: next_rdata = pa_dig;
                REG_PA_LATCH: next_rdata = pa_latch;
                REG_PA_DIR: next_rdata = pa_dir;
                REG_ANA_LOW: next_rdata = ana_low;
                REG_PB_PINS: next_rdata = pb_dig;
                REG_PB_LATCH: next_rdata = pb_latch;
                REG_PB_DIR: next_rdata = pb_dir;
                REG_ANA_HIGH: next_rdata = ana_high;
                REG_INT_TWO: next_rdata = int_two;
                REG_INT_MAIN: next_rdata = {7'h00, port_change_flag};
                default: next_rdata = ZERO_BYTE;
            endcase
        end
    end

    // compare eligible upper pins against the snapshot
    always_comb begin
        next_ioc_mismatch = |((pb_dig ^ {ioc_snap, 4'h0}) & pb_dir & PB_IOC_MASK);
    end

    // pin drive, taken from next values so outputs leave flip-flops
    always_comb begin
        next_pa_pin_out = next_pa_latch;
        next_pa_pin_oe_n = next_pa_dir | ~PA_IMPL_MASK;
        if (rc_ec_mode) begin
            next_pa_pin_out[PA_CLKOUT_PIN] = next_div_cnt[DIV_W-1];
            next_pa_pin_oe_n[PA_CLKOUT_PIN] = 1'b0;
        end
        next_pb_pin_out = next_pb_latch;
        next_pb_pin_oe_n = next_pb_dir;
        // pull-ups only on inputs; output drivers would fight them
        next_pb_pullup_en = next_pb_dir & {PB_WIDTH{~next_int_two[PULLUP_BIT]}};
        next_wake_request = next_port_change_flag;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pa_latch <= LATCH_RST;
            pa_dir <= PA_DIR_RST;
            ana_low <= ANA_RST;
            pb_latch <= LATCH_RST;
            pb_dir <= PB_DIR_RST;
            ana_high <= ANA_RST;
            int_two <= INT_TWO_RST;
            port_change_flag <= 1'b0;
            ioc_snap <= 4'h0;
            ioc_mismatch <= 1'b0;
            div_cnt <= '0;
            rdata <= ZERO_BYTE;
            pa_pin_out <= LATCH_RST;
            pa_pin_oe_n <= 8'hFF;
            pb_pin_out <= LATCH_RST;
            pb_pin_oe_n <= PB_DIR_RST;
            pb_pullup_en <= '0;
            wake_request <= 1'b0;
        end else begin
            pa_latch <= next_pa_latch;
            pa_dir <= next_pa_dir;
            ana_low <= next_ana_low;
            pb_latch <= next_pb_latch;
            pb_dir <= next_pb_dir;
            ana_high <= next_ana_high;
            int_two <= next_int_two;
            port_change_flag <= next_port_change_flag;
            ioc_snap <= next_ioc_snap;
            ioc_mismatch <= next_ioc_mismatch;
            div_cnt <= next_div_cnt;
            rdata <= next_rdata;
            pa_pin_out <= next_pa_pin_out;
            pa_pin_oe_n <= next_pa_pin_oe_n;
            pb_pin_out <= next_pb_pin_out;
            pb_pin_oe_n <= next_pb_pin_oe_n;
            pb_pullup_en <= next_pb_pullup_en;
            wake_request <= next_wake_request;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_pb_read;
        rd && (addr == REG_PB_PINS);
    endsequence

    sequence s_pins_steady;
        pb_dig == $past(pb_dig);
    endsequence

    a_dir_sets_hiz: assert property (
        (wr && addr == REG_PB_DIR) |=> (pb_pin_oe_n == $past(wdata))
    ) else $error("direction write not reflected on pin enables");

    a_latch_drives_pin: assert property (
        (wr && addr == REG_PB_LATCH) |=> (pb_pin_out == $past(wdata))
    ) else $error("latch write not driven on pins");

    a_latch_read_back: assert property (
        (wr && addr == REG_PB_LATCH) ##1 (rd && addr == REG_PB_LATCH)
            |=> (rdata == $past(wdata, 2))
    ) else $error("latch read does not return stored value");

    a_pullup_gating: assert property (
        pb_pullup_en == (pb_dir & {PB_WIDTH{~int_two[PULLUP_BIT]}})
    ) else $error("pull-up enable wrong for direction or global bit");

    a_reset_state: assert property (@(posedge clock) disable iff (1'b0)
        !rstn |=> (pb_pullup_en == '0 && ana_high == ANA_RST && !ana_low[ANA_CH4_BIT])
    ) else $error("pull-ups or analog defaults wrong after reset");

    a_mismatch_sets_flag: assert property (
        ioc_mismatch |=> (port_change_flag && wake_request)
    ) else $error("mismatch did not set change flag");

    a_read_ends_mismatch: assert property (
        s_pb_read ##1 s_pins_steady |=> !ioc_mismatch
    ) else $error("mismatch persists after port read");

    a_flag_clear_ok: assert property (
        (wr && addr == REG_INT_MAIN && !wdata[FLAG_BIT] && !ioc_mismatch)
            |=> !port_change_flag
    ) else $error("flag clear ignored without mismatch");

    a_output_no_ioc: assert property (
        (pb_dir[7:IOC_LSB] == 4'h0) |=> !ioc_mismatch
    ) else $error("output pin took part in change detection");

    a_analog_reads_zero: assert property (
        (rd && addr == REG_PA_PINS && !ana_low[ANA_CH4_BIT]) |=> !rdata[PA_ANALOG_PIN]
    ) else $error("analog pin five read nonzero");

    a_unimpl_bit_zero: assert property (
        (rd && (addr == REG_PA_PINS || addr == REG_PA_LATCH || addr == REG_PA_DIR))
            |=> !rdata[PA_UNIMPL_BIT]
    ) else $error("unimplemented bit four read nonzero");

    a_clkout_override: assert property (
        rc_ec_mode ##1 rc_ec_mode |-> !pa_pin_oe_n[PA_CLKOUT_PIN]
            && (pa_pin_out[PA_CLKOUT_PIN] == div_cnt[DIV_W-1])
    ) else $error("cycle clock not driven on pin six");
endmodule

//--- rtl/gpc_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes pins are asynchronous to clock
module gpc_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync_out;

    // first stage feeds only the second stage
    always_comb begin
        next_stage_one = async_in;
        next_sync_out = stage_one;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= next_stage_one;
            sync_out <= next_sync_out;
        end
    end
endmodule

//--- verification/gpc_pin_model.sv
// behavioural model of the circuitry wired to one 8-pin port
// assumes the port's drive, enable and pull-up outputs; one clock for float churn
module gpc_pin_model (
    input wire logic clock,
    input wire logic [7:0] drv_out,
    input wire logic [7:0] drv_oe_n,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_q = 8'h00;
    // -----------------------------------------------------------------
    // wire resolution
    // -----------------------------------------------------------------
    // an active driver on the device side wins over the outside drive
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!drv_oe_n[i]) begin
                pin_level[i] = drv_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = float_q[i];
            end
        end
    end
    // a floating pin flips every cycle so a stale value never passes
    always @(posedge clock) begin
        float_q <= ~pin_level;
    end
endmodule

//--- verification/testbench.sv
// self-checking bench for the two-port pin block with change detection
// assumes a 50 MHz clock, synchronous active-low reset and the strobe register port
module testbench
    import gpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d;} gpc_row_type;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rc_ec_mode = 1'b0;
    logic [7:0] rdata, pa_pin_in, pa_pin_out, pa_pin_oe_n;
    logic [7:0] pb_pin_in, pb_pin_out, pb_pin_oe_n, pb_pullup_en;
    logic wake_request;
    logic [7:0] pa_ext = 8'hFF;
    logic [7:0] pb_ext = 8'h5A;
    logic [7:0] pb_ext_en = 8'hFF;
    logic [7:0] seen;
    gpc_row_type rows [0:14];
    int failures = 0;
    int checks_done = 0;
    // -----------------------------------------------------------------
    // design, pin models and clock
    // -----------------------------------------------------------------
    gpc_port gpc_port_inst (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out),
        .pa_pin_oe_n(pa_pin_oe_n), .pb_pin_in(pb_pin_in), .pb_pin_out(pb_pin_out),
        .pb_pin_oe_n(pb_pin_oe_n), .pb_pullup_en(pb_pullup_en), .rc_ec_mode(rc_ec_mode),
        .wake_request(wake_request));
    gpc_pin_model pa_model (.clock(clock), .drv_out(pa_pin_out), .drv_oe_n(pa_pin_oe_n),
        .pullup_en(8'h00), .ext_val(pa_ext), .ext_en(8'hFF), .pin_level(pa_pin_in));
    gpc_pin_model pb_model (.clock(clock), .drv_out(pb_pin_out), .drv_oe_n(pb_pin_oe_n),
        .pullup_en(pb_pullup_en), .ext_val(pb_ext), .ext_en(pb_ext_en),
        .pin_level(pb_pin_in));
    always #10 clock = ~clock;
    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so look there
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clock);
        failures++;
        end_of_test();
    end
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        rows = '{'{1'b0, REG_PA_LATCH, LATCH_RST}, '{1'b0, REG_PA_DIR, PA_DIR_RST},
            '{1'b0, REG_ANA_LOW, ANA_RST}, '{1'b0, REG_PB_LATCH, LATCH_RST},
            '{1'b0, REG_PB_DIR, PB_DIR_RST}, '{1'b0, REG_ANA_HIGH, ANA_RST},
            '{1'b0, REG_INT_TWO, INT_TWO_RST}, '{1'b0, 4'hF, 8'h00},
            '{1'b1, REG_PA_LATCH, 8'hFF}, '{1'b0, REG_PA_LATCH, 8'hEF},
            '{1'b1, 4'hF, 8'hFF}, '{1'b0, 4'hF, 8'h00}, '{1'b1, REG_PB_LATCH, 8'hA5},
            '{1'b0, REG_PB_LATCH, 8'hA5}, '{1'b0, REG_PB_PINS, 8'h50}};
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                reg_wr(rows[i].a, rows[i].d);
            end else begin
                reg_rd(rows[i].a, seen);
                check("register", seen, rows[i].d);
            end
        end
        $display("test register table done");
        // drive, direction and pull-up gating on the second port
        reg_wr(REG_PB_DIR, 8'h0F);
        reg_wr(REG_PB_LATCH, 8'hC3);
        reg_wr(REG_INT_TWO, 8'h00);
        settle(3);
        check("pb_oe_n", pb_pin_oe_n, 8'h0F);
        check("pb_drive", pb_pin_out & ~pb_pin_oe_n, 8'hC0);
        check("pb_pullup", pb_pullup_en, 8'h0F);
        reg_rd(REG_PB_PINS, seen);
        check("pb_pins", seen, 8'hC0);
        reg_wr(REG_PB_DIR, 8'hFF);
        pb_ext_en <= 8'h0F;
        settle(4);
        check("pb_pullup", pb_pullup_en, 8'hFF);
        reg_rd(REG_PB_PINS, seen);
        check("pb_pulled", seen, 8'hF0);
        $display("test drive and pull-up done");
        // change detection: settle a snapshot, then clear the flag
        reg_wr(REG_ANA_HIGH, 8'h0F);
        pb_ext_en <= 8'hFF;
        pb_ext <= 8'h00;
        settle(4);
        reg_rd(REG_PB_PINS, seen);
        check("pb_pins", seen, 8'h00);
        settle(4);
        reg_wr(REG_INT_MAIN, 8'h00);
        settle(2);
        check("wake_idle", {7'h00, wake_request}, 8'h00);
        pb_ext <= 8'h0F;
        settle(8);
        check("wake_low_pins", {7'h00, wake_request}, 8'h00);
        reg_wr(REG_PB_DIR, 8'h7F);
        reg_wr(REG_PB_LATCH, 8'h80);
        settle(8);
        check("wake_output_pin", {7'h00, wake_request}, 8'h00);
        reg_wr(REG_PB_DIR, 8'hFF);
        settle(4);
        reg_rd(REG_PB_PINS, seen);
        settle(4);
        reg_wr(REG_INT_MAIN, 8'h00);
        pb_ext <= 8'h8F;
        // look after the clear edge has settled, not in its own time step
        settle(1);
        check("wake_cleared", {7'h00, wake_request}, 8'h00);
        for (int n = 0; n < 8 && wake_request !== 1'b1; n++) begin
            settle(1);
        end
        check("wake_set", {7'h00, wake_request}, 8'h01);
        reg_rd(REG_INT_MAIN, seen);
        check("change_flag", seen & 8'h01, 8'h01);
        // a clear while the mismatch stands must lose in that very cycle
        reg_wr(REG_INT_MAIN, 8'h00);
        settle(0);
        check("wake_sticky", {7'h00, wake_request}, 8'h01);
        settle(2);
        reg_rd(REG_INT_MAIN, seen);
        check("flag_sticky", seen & 8'h01, 8'h01);
        reg_rd(REG_PB_PINS, seen);
        check("pb_pins", seen, 8'h8F);
        settle(2);
        reg_wr(REG_INT_MAIN, 8'h00);
        settle(1);
        check("wake_clear", {7'h00, wake_request}, 8'h00);
        reg_rd(REG_INT_MAIN, seen);
        check("change_flag", seen & 8'h01, 8'h00);
        $display("test change detection done");
        // first port: unimplemented bit and the analog pin five
        reg_wr(REG_ANA_LOW, 8'hFF);
        settle(3);
        reg_rd(REG_PA_PINS, seen);
        check("pa_pins", seen, 8'hEF);
        reg_wr(REG_ANA_LOW, 8'hEF);
        reg_rd(REG_PA_PINS, seen);
        check("pa_pin_five", seen, 8'hCF);
        reg_wr(REG_PA_DIR, 8'h00);
        reg_wr(REG_PA_LATCH, 8'h20);
        settle(2);
        check("pa_out", pa_pin_out & 8'h20, 8'h20);
        check("pa_oe_n", pa_pin_oe_n & 8'hEF, 8'h00);
        // cycle clock out ignores the direction bit
        @(posedge clock);
        rc_ec_mode <= 1'b1;
        reg_wr(REG_PA_DIR, 8'hFF);
        settle(2);
        check("clk_oe", {7'h00, pa_pin_oe_n[6]}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            settle(1);
            seen[i] = pa_pin_out[6];
        end
        for (int i = 0; i < 4; i++) begin
            check("clk_half", {7'h00, seen[i + 2]}, {7'h00, ~seen[i]});
            check("clk_period", {7'h00, seen[i + 4]}, {7'h00, seen[i]});
        end
        $display("test first port done");
        // reset in mid-run brings back the power-on state
        @(posedge clock);
        rc_ec_mode <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        settle(1);
        check("pa_oe_n", pa_pin_oe_n, 8'hFF);
        check("pa_out", pa_pin_out, 8'h00);
        check("pb_oe_n", pb_pin_oe_n, 8'hFF);
        check("pb_pullup", pb_pullup_en, 8'h00);
        check("pb_out", pb_pin_out, 8'h00);
        check("wake_reset", {7'h00, wake_request}, 8'h00);
        reg_rd(REG_INT_TWO, seen);
        check("int_two", seen, INT_TWO_RST);
        $display("test reset done");
        end_of_test();
    end
endmodule
